// [rtl/qx_pkg.sv]
package qx_pkg;

  // width of the quasi-bidirectional port
  localparam int QX_PORT_W = 8;

  // fixed upper four address bits of each variant
  localparam logic [3:0] QX_ADDR_FIXED_BASE = 4'h4; // 7-bit range 20h..27h
  localparam logic [3:0] QX_ADDR_FIXED_ALT = 4'h7; // 7-bit range 38h..3Fh

  // value of the port register after reset: every pin a weak-high input
  localparam logic [7:0] QX_PORT_RESET = 8'hFF;

  // direction bit of the address byte
  localparam logic QX_DIR_READ = 1'b1;

  // bit count of one byte on the bus
  localparam logic [3:0] QX_BYTE_BITS = 4'h8;

  // position of each pin inside the synchronised bundle
  localparam int QX_POS_SCL = 0;
  localparam int QX_POS_SDA = 1;
  localparam int QX_POS_IO = 2; // eight port pins from here
  localparam int QX_POS_STRAP = 10; // three strap pins, lo first
  localparam int QX_POS_ALT = 13; // variant select strap
  localparam int QX_SYNC_W = 14;

  // reset level of the synchronised bundle: lines idle high
  localparam logic [13:0] QX_SYNC_RESET = 14'h03FF;

  // bus-side states of the serial slave
  typedef enum logic [2:0] {
    QX_IDLE,
    QX_ADDR,
    QX_ADDR_ACK,
    QX_WR_DATA,
    QX_WR_ACK,
    QX_RD_DATA,
    QX_RD_ACK,
    QX_IGNORE
  } qx_state_t;

endpackage

// [rtl/qx_sync_if.sv]
`timescale 1ns/1ps
// carries raw pin levels into the synchroniser and filtered levels back
interface qx_sync_if #(
  parameter int W = 14
);
  logic [W-1:0] raw; // asynchronous pin levels
  logic [W-1:0] level; // filtered, clock-domain levels

  modport sync (input raw, output level);
  modport core (output raw, input level);
endinterface

// [rtl/qx_sync.sv]
`timescale 1ns/1ps
// three-stage synchroniser; a bit changes once stages two and three agree
module qx_sync
  import qx_pkg::*;
#(
  parameter int W = 14,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  qx_sync_if.sync pins
);

  logic [W-1:0] stage1; // metastability catcher, read only by stage2
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] level;
  logic [W-1:0] next_level;

  // accept a new level only where the two settled stages agree
  always_comb begin
    next_level = ((stage2 ~^ stage3) & stage3) |
                 ((stage2 ^ stage3) & level);
  end

  // register the chain and the filtered level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      level <= RST_VAL;
    end else if (ce) begin
      stage1 <= pins.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

  assign pins.level = level;

endmodule // qx_sync

// [rtl/qx_expander.sv]
`timescale 1ns/1ps
module qx_expander
  import qx_pkg::*;
#(
  parameter int PORT_W = QX_PORT_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [PORT_W-1:0] io_in,
  output logic [PORT_W-1:0] io_out,
  output logic [PORT_W-1:0] io_oe,
  output logic [PORT_W-1:0] io_weak_en,
  input wire logic addr_strap_hi,
  input wire logic addr_strap_mid,
  input wire logic addr_strap_lo,
  input wire logic alt_variant,
  output logic [PORT_W-1:0] port_data_q,
  output logic bus_busy
);

  // the address match is used only on the bus path, at the end of the address byte
  function automatic logic addr_hit(input logic [6:0] addr,
                                    input logic [2:0] straps,
                                    input logic alt);
    logic [3:0] fixed;
    fixed = alt ? QX_ADDR_FIXED_ALT : QX_ADDR_FIXED_BASE;
    return addr == {fixed, straps};
  endfunction

  // one bundle keeps every pin on the same filter delay, so scl and sda
  // are never seen in the wrong order by the bus logic; the cost is a
  // few cycles of lag, far below a standard-mode half bit
  qx_sync_if #(.W(QX_SYNC_W)) sync_bus ();

  // all pins enter through the same three-stage filter
  assign sync_bus.raw = {alt_variant, addr_strap_hi, addr_strap_mid,
                         addr_strap_lo, io_in, sda_in, scl_in};

  qx_sync #(
    .W(QX_SYNC_W),
    .RST_VAL(QX_SYNC_RESET)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .pins(sync_bus.sync)
  );

  // filtered pin levels
  logic scl_lvl; // serial clock after filter
  logic sda_lvl; // serial data after filter
  logic [PORT_W-1:0] io_lvl; // live port pin levels
  logic [2:0] strap_lvl; // address straps
  logic alt_lvl; // variant select

  assign scl_lvl = sync_bus.level[QX_POS_SCL];
  assign sda_lvl = sync_bus.level[QX_POS_SDA];
  assign io_lvl = sync_bus.level[QX_POS_IO +: PORT_W];
  assign strap_lvl = sync_bus.level[QX_POS_STRAP +: 3];
  assign alt_lvl = sync_bus.level[QX_POS_ALT];
  // straps are filtered like the bus lines; a strap moved in the middle
  // of a transfer only counts for the next address byte

  // previous filtered levels for edge detection
  logic scl_prev;
  logic sda_prev;

  // edge and bus-condition strobes, one cycle each
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise = scl_lvl & ~scl_prev;
  assign scl_fall = ~scl_lvl & scl_prev;
  // data may only move while the clock is low; a move with clock high
  // is a bus condition
  assign start_cond = scl_lvl & scl_prev & sda_prev & ~sda_lvl;
  assign stop_cond = scl_lvl & scl_prev & ~sda_prev & sda_lvl;
  // limitation: a data and a clock change inside one filtered cycle
  // count as no condition; a standard-mode master never does that

  // bus state and datapath registers
  qx_state_t state;
  qx_state_t next_state;
  logic [3:0] bit_cnt; // bits moved in the current byte
  logic [3:0] next_bit_cnt;
  logic [7:0] rx_shift; // bits received, msb first
  logic [7:0] next_rx_shift;
  logic [7:0] tx_shift; // bits to send, msb first
  logic [7:0] next_tx_shift;
  logic is_read; // direction of the current transfer
  logic next_is_read;
  logic master_ack; // master answer to the last sent byte
  logic next_master_ack;
  logic [PORT_W-1:0] port_data; // the one and only port register
  logic [PORT_W-1:0] next_port_data;
  logic boost; // strong pull-up window for ones
  logic next_boost;
  logic sda_drive; // pull serial data low
  logic next_sda_drive;
  logic [PORT_W-1:0] io_drive; // strong drive enables per pin
  logic [PORT_W-1:0] next_io_drive;
  // drive enables are registered so the pins never see decode glitches

  // next-state logic of the serial slave
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_rx_shift = rx_shift;
    next_tx_shift = tx_shift;
    next_is_read = is_read;
    next_master_ack = master_ack;
    next_port_data = port_data;
    next_boost = boost;
    // every branch below starts from the held values above, so no latch
    // is inferred and a quiet bus leaves all state untouched

    if (start_cond) begin
      // a start or repeated start always begins a fresh address byte
      next_state = QX_ADDR;
      next_bit_cnt = '0;
      next_boost = 1'b0;
    end else if (stop_cond) begin
      // port keeps the value of the last acknowledged byte;
      // a partly received or unsent byte is simply dropped
      next_state = QX_IDLE;
      next_bit_cnt = '0;
      next_boost = 1'b0;
    end else begin
      case (state)
        QX_IDLE: begin
          // wait for a start; everything else on the bus is ignored
          // a stop or stray clocking while idle changes nothing here
          next_state = QX_IDLE;
        end
        QX_ADDR, QX_WR_DATA: begin
          // sample data on the clock rise, msb first
          if (scl_rise) begin
            next_rx_shift = {rx_shift[6:0], sda_lvl};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          // the fall after the eighth bit opens the acknowledge slot
          // the count reaches eight on the eighth rise, then waits here
          if (scl_fall && bit_cnt == QX_BYTE_BITS) begin
            next_bit_cnt = '0;
            if (state == QX_WR_DATA) begin
              next_state = QX_WR_ACK;
            end else if (addr_hit(rx_shift[7:1], strap_lvl, alt_lvl)) begin
              next_is_read = (rx_shift[0] == QX_DIR_READ);
              next_state = QX_ADDR_ACK;
            end else begin
              next_state = QX_IGNORE;
            end
          end
        end
        QX_ADDR_ACK: begin
          // a read samples the live pins while the ack clock is high
          // a write only holds the ack low here; no boost on this slot
          if (scl_rise && is_read) begin
            next_tx_shift = io_lvl;
          end
          if (scl_fall) begin
            next_state = is_read ? QX_RD_DATA : QX_WR_DATA;
          end
        end
        QX_WR_ACK: begin
          // the received byte reaches the pins as the ack clock rises;
          // each byte overwrites the previous one, no count limit
          if (scl_rise) begin
            next_port_data = rx_shift;
            next_boost = 1'b1;
          end
          // boost ends with the high half of the ack clock
          // so a pin held low from outside is only fought for half a bit
          if (scl_fall) begin
            next_boost = 1'b0;
            next_state = QX_WR_DATA;
          end
        end
        QX_RD_DATA: begin
          // shift on each fall; the eighth fall hands sda to the master
          // a one is shifted in behind so a stray extra fall releases sda
          if (scl_fall) begin
            next_tx_shift = {tx_shift[6:0], 1'b1};
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == QX_BYTE_BITS - 4'h1) begin
              next_bit_cnt = '0;
              next_state = QX_RD_ACK;
            end
          end
        end
        QX_RD_ACK: begin
          // master answer sampled on the rise; pins taken for next byte
          if (scl_rise) begin
            next_master_ack = ~sda_lvl;
            next_tx_shift = io_lvl;
          end
          // a nack means the master ends with a stop; stay off the bus
          // the answer was taken at the rise, so a late sda glitch in
          // the high half cannot flip the decision
          if (scl_fall) begin
            next_state = master_ack ? QX_RD_DATA : QX_IGNORE;
          end
        end
        QX_IGNORE: begin
          // released until the next start or stop
          next_state = QX_IGNORE;
        end
        // an illegal code falls back to idle and waits for a start
        default: begin
          next_state = QX_IDLE;
        end
      endcase
    end
  end

  // output drive follows the next state so both change together
  always_comb begin
    // address and write acknowledge slots pull low; a read pulls low for each zero
    next_sda_drive = (next_state == QX_ADDR_ACK) ||
                     (next_state == QX_WR_ACK) ||
                     (next_state == QX_RD_DATA && !next_tx_shift[7]);
    // decoding the next state keeps the ack edge level with the state
    // change instead of one cycle behind it
    // zeros sink for good, ones drive high only inside the boost
    next_io_drive = ~next_port_data | {PORT_W{next_boost}};
  end

  // register every piece of bus state; ce freezes it all
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // reset reinitialises the bus machine and makes all pins inputs
      state <= QX_IDLE;
      bit_cnt <= '0;
      rx_shift <= '0;
      tx_shift <= '1;
      is_read <= 1'b0;
      master_ack <= 1'b0;
      port_data <= QX_PORT_RESET;
      boost <= 1'b0;
      sda_drive <= 1'b0;
      io_drive <= '0;
      // edge history idles high like the lines, so no false edge follows
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else if (ce) begin
      // with ce low nothing moves, so a frozen block keeps its pins
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      rx_shift <= next_rx_shift;
      tx_shift <= next_tx_shift;
      is_read <= next_is_read;
      master_ack <= next_master_ack;
      port_data <= next_port_data;
      boost <= next_boost;
      sda_drive <= next_sda_drive;
      io_drive <= next_io_drive;
      scl_prev <= scl_lvl;
      sda_prev <= sda_lvl;
    end
  end

  // open-drain serial data: the level is always low when enabled
  assign sda_out = 1'b0;
  assign sda_oe = sda_drive;
  // the line is only ever released or pulled, never driven high, so
  // another device pulling at the same time cannot cause contention

  // strong drive level equals the latched bit: low sinks, high boosts
  assign io_out = port_data;
  assign io_oe = io_drive;
  // weak source stays on for every bit latched high
  assign io_weak_en = port_data;
  // outside the boost, an outside low on a pin latched high only fights the weak source,
  // which is how a pin latched high doubles as an input

  // status views of the block
  assign port_data_q = port_data;
  assign bus_busy = (state != QX_IDLE);
  // busy also covers an ignored transfer, up to its stop

endmodule // qx_expander

// [test/qx_expander_properties.sv]
`timescale 1ns/1ps
// pin checks on the expander
module qx_expander_properties
  import qx_pkg::*;
#(
  parameter int PORT_W = QX_PORT_W
) (
  input logic ref_clk,
  input logic rst,
  input logic scl_in,
  input logic sda_out,
  input logic sda_oe,
  input logic [PORT_W-1:0] io_out,
  input logic [PORT_W-1:0] io_oe,
  input logic [PORT_W-1:0] io_weak_en,
  input logic [PORT_W-1:0] port_data_q,
  input logic bus_busy
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // port high and bus idle once reset lets go
  chk_reset_idle: assert property ($fell(rst) |->
    port_data_q == QX_PORT_RESET && io_oe == '0 && !sda_oe && !bus_busy)
    else $error("not idle after reset");
  // a latched zero always keeps its sink on
  chk_sink_held: assert property ((port_data_q | io_oe) == '1)
    else $error("sink off on zero bit");
  // drive level and weak source follow the latch bit for bit
  chk_drive_follow: assert property (
    io_out == port_data_q && io_weak_en == port_data_q)
    else $error("drive differs from latch");
  // boost must be gone well into the clock low half
  chk_boost_short: assert property (
    (!scl_in) [*8] |-> (io_oe & port_data_q) == '0)
    else $error("boost while clock low");
  // a fresh latch value opens the strong drive on every pin
  chk_boost_on: assert property (
    $changed(port_data_q) |-> io_oe == '1)
    else $error("no boost with new latch");
  // the latch moves only at a clock high inside a transfer
  chk_latch_ack: assert property (
    $changed(port_data_q) |-> scl_in && $past(bus_busy))
    else $error("latch moved outside ack");
  // data line only starts to be pulled while the clock is low
  chk_sda_setup: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda pulled at clock high");
  // and stays put through the clock high half
  chk_sda_steady: assert property (scl_in [*6] |-> $stable(sda_oe))
    else $error("sda moved at clock high");
  // open drain, never pulled while idle
  chk_sda_release: assert property (
    !sda_out && (bus_busy || !sda_oe)) else $error("sda pulled when idle");
endmodule // qx_expander_properties

bind qx_expander qx_expander_properties #(.PORT_W(PORT_W))
  u_qx_expander_properties (.ref_clk(ref_clk), .rst(rst),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .io_out(io_out),
  .io_oe(io_oe), .io_weak_en(io_weak_en), .port_data_q(port_data_q),
  .bus_busy(bus_busy));

// [test/qx_master.sv]
`timescale 1ns/1ps
// bus master: drives the clock, sinks data open drain
module qx_master (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  localparam int HB = 12; // a third of a bit, beyond the pin filter lag
  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
  end
  task automatic hb;
    repeat (HB) @(negedge ref_clk);
  endtask
  // start (f=1) or stop (f=0): data edge while clock high
  task automatic cond(input logic f);
    hb();
    sda_m <= f;
    hb();
    scl <= 1'h1;
    hb();
    sda_m <= ~f;
    hb();
    if (f) scl <= 1'h0;
  endtask
  // one bit: data set in clock low, line taken at end of high
  task automatic bit_x(input logic b, output logic r);
    hb();
    sda_m <= b;
    hb();
    scl <= 1'h1;
    hb();
    r = sda;
    scl <= 1'h0;
  endtask
  // byte msb first, then the ack bit; a one releases the line
  task automatic xfer(input logic [7:0] tx, input logic ai,
    output logic [7:0] rx, output logic ao);
    for (int i = 7; i >= 0; i--)
      bit_x(tx[i], rx[i]);
    bit_x(ai, ao);
  endtask
endmodule // qx_master

// [test/qx_expander_tb_top.sv]
`timescale 1ns/1ps
// bench: case table, then edge cases by hand
module qx_expander_tb_top
  import qx_pkg::*;
();
  // straps, address, byte, outside drive, acked
  typedef struct packed {
    logic alt;
    logic [2:0] st;
    logic [6:0] adr;
    logic [7:0] dat;
    logic [7:0] ext;
    logic ack;
  } qx_row_t;
  qx_row_t rows [6] = '{
    '{1'h0, 3'h0, 7'h20, 8'hA5, 8'hFF, 1'h1},
    '{1'h0, 3'h7, 7'h27, 8'h3C, 8'hF0, 1'h1},
    '{1'h1, 3'h0, 7'h38, 8'h0F, 8'hFF, 1'h1},
    '{1'h1, 3'h5, 7'h3D, 8'hFF, 8'h5A, 1'h1},
    '{1'h0, 3'h2, 7'h3A, 8'h00, 8'hFF, 1'h0},
    '{1'h1, 3'h3, 7'h23, 8'h00, 8'hFF, 1'h0}};
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic alt = 1'h0;
  logic [2:0] st = 3'h0;
  logic [7:0] ext = 8'hFF; // outside drive on the pins
  logic [7:0] io_in = 8'hFF;
  logic [7:0] exp_port = QX_PORT_RESET;
  logic [7:0] rx, io_out, io_oe, io_weak_en, port_data_q;
  logic ak, dak, scl, sda_m, sda_oe, sda_out, bus_busy;
  logic ce = 1'h1; // clock enable, lowered once to freeze the block
  int mismatches = 0;
  int samples_checked = 0;
  // pulled up, either side sinks; the device pulls to its output level
  wire logic sda = sda_m & ~(sda_oe & ~sda_out);
  qx_expander u_qx_expander (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .io_weak_en(io_weak_en), .addr_strap_hi(st[2]),
    .addr_strap_mid(st[1]), .addr_strap_lo(st[0]), .alt_variant(alt),
    .port_data_q(port_data_q), .bus_busy(bus_busy));
  qx_master u_qx_master (.ref_clk(ref_clk), .sda(sda), .scl(scl),
    .sda_m(sda_m));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // a latched zero sinks the pin, else the outside drive wins
  always @(negedge ref_clk) begin
    io_in <= ext & ~(io_oe & ~io_out);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d of %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // whole transfer: address byte, one byte, master nack, stop
  task automatic txn(input logic [7:0] ab, input logic [7:0] d);
    u_qx_master.cond(1'h1);
    u_qx_master.xfer(ab, 1'h1, rx, ak);
    u_qx_master.xfer(d, 1'h1, rx, dak);
    u_qx_master.cond(1'h0);
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    rst <= 1'h0;
    @(negedge ref_clk);
    chk(port_data_q & io_weak_en & ~io_oe, QX_PORT_RESET);
    foreach (rows[i]) begin
      alt <= rows[i].alt;
      st <= rows[i].st;
      ext <= rows[i].ext;
      repeat (10) @(negedge ref_clk);
      txn({rows[i].adr, 1'h0}, rows[i].dat);
      chk({6'h0, ak, dak}, {6'h0, {2{~rows[i].ack}}});
      exp_port = rows[i].ack ? rows[i].dat : exp_port;
      chk(port_data_q, exp_port);
      chk(io_oe, ~exp_port);
      chk({7'h0, bus_busy}, 8'h00);
      txn({rows[i].adr, 1'h1}, 8'hFF);
      chk(rx, rows[i].ack ? exp_port & rows[i].ext : 8'hFF);
    end
    // two bytes in one transfer, then a stop in mid byte
    alt <= 1'h0;
    st <= 3'h1;
    repeat (10) @(negedge ref_clk);
    u_qx_master.cond(1'h1);
    u_qx_master.xfer({QX_ADDR_FIXED_BASE, 3'h1, 1'h0}, 1'h1, rx, ak);
    u_qx_master.xfer(8'h81, 1'h1, rx, dak);
    chk(port_data_q, 8'h81);
    u_qx_master.xfer(8'h7E, 1'h1, rx, ak);
    chk({6'h0, ak, dak}, 8'h00);
    chk(port_data_q, 8'h7E);
    repeat (4) u_qx_master.bit_x(1'h0, dak);
    u_qx_master.cond(1'h0);
    chk(port_data_q, 8'h7E);
    // two reads: each byte takes the pins at the ack before it
    txn(8'h42, 8'hFF);
    ext <= 8'hC3;
    repeat (10) @(negedge ref_clk);
    u_qx_master.cond(1'h1);
    u_qx_master.xfer(8'h43, 1'h1, rx, ak);
    ext <= 8'h3C;
    u_qx_master.xfer(8'hFF, 1'h0, rx, dak);
    chk(rx, 8'hC3);
    u_qx_master.xfer(8'hFF, 1'h1, rx, dak);
    chk(rx, 8'h3C);
    u_qx_master.cond(1'h0);
    // ce low freezes the block: a whole write goes unseen
    ce <= 1'h0;
    txn(8'h42, 8'h00);
    chk({6'h0, ak, dak}, 8'h03);
    chk(port_data_q, 8'hFF);
    ce <= 1'h1;
    repeat (10) @(negedge ref_clk);
    // reset in mid run with zeros latched
    txn(8'h42, 8'h00);
    rst <= 1'h1;
    repeat (4) @(negedge ref_clk);
    rst <= 1'h0;
    @(negedge ref_clk);
    chk(port_data_q & ~io_oe, QX_PORT_RESET);
    report_and_stop();
  end
  // cut a hang short: a full run needs about 13560 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end
endmodule // qx_expander_tb_top
